// ==== logic/fcw_drive.sv ====
// drive end: command word interpreter, state machine, status and mirrors
`timescale 1ns/1ns
// Operation
// - at most twelve 16-bit words each way
// - cyclic words are 16 or 32 bits
// - reference is sign plus 15-bit magnitude
// - negative reference is two's complement
// - debug mirrors command and status words
// - debug mirrors both raw references
// - debug mirrors both raw actual values
// - per-reference type selects scaling
// - per-word type selects actual value signal
// - bit 0 set: ready to operate
// - bit 0 clear: ramp stop, then ready
// - bit 1 clear: coast stop, then inhibited
// - bit 2 clear: quick stop, then inhibited
// - bit 3 with run enable: operation enabled
// - bit 3 clear: operation inhibited
// - bit 4 clear: ramp output forced zero
// - bit 5 clear: ramp output frozen
// - bit 6 set: operating, network source only
// - state follows command, status returned
// - network data used only when selected
// - bit 6 clear: ramp input zero
// - bit 7 rising: fault reset if selected
module fcw_drive
  import fcw_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  fcw_link_if.drive        link,
  input  wire fcw_dbg_e    dbg_mode_i,
  input  wire logic [1:0]  ref1_type_i,
  input  wire logic [1:0]  ref2_type_i,
  input  wire logic [1:0]  act1_type_i,
  input  wire logic [1:0]  act2_type_i,
  input  wire logic        net_ctrl_sel_i,
  input  wire logic        net_ref_sel_i,
  input  wire logic        net_run_en_sel_i,
  input  wire logic        net_ramp_in_sel_i,
  input  wire logic        net_reset_sel_i,
  input  wire logic [15:0] local_cmd_i,
  input  wire logic [15:0] local_ref_i,
  input  wire logic        local_run_en_i,
  input  wire logic        fault_i,
  input  wire logic        stop_done_i,
  input  wire logic [15:0] speed_act_i,
  input  wire logic [15:0] torque_act_i,
  output fcw_state_e       state_o,
  output logic [15:0]      ramp_out_o,
  output logic             coast_o,
  output logic             quick_o,
  output logic [15:0]      dbg_cmd_o,
  output logic [15:0]      dbg_stat_o,
  output logic [15:0]      dbg_ref1_o,
  output logic [15:0]      dbg_ref2_o,
  output logic [15:0]      dbg_act1_o,
  output logic [15:0]      dbg_act2_o
);
  import fcw_pkg::*;
  // ==========================================================================
  // reference scaling
  logic [15:0] ref1_scaled, ref2_scaled;
  fcw_ref_scale u_ref1 (.raw_i(link.ref1_word), .type_i(ref1_type_i), .scaled_o(ref1_scaled));
  fcw_ref_scale u_ref2 (.raw_i(link.ref2_word), .type_i(ref2_type_i), .scaled_o(ref2_scaled));

  function automatic logic [15:0] act_pick(input logic [1:0] t, input logic [15:0] spd,
                                           input logic [15:0] trq, input logic [15:0] rmp);
    unique case (t)
      ACT_SPEED:  act_pick = spd;
      ACT_TORQUE: act_pick = trq;
      ACT_FREQ:   act_pick = {1'b0, spd[15:1]};
      default:    act_pick = rmp;
    endcase
  endfunction
  // ==========================================================================
  // state machine and ramp
  fcw_state_e  st_ff, nxt_st;
  logic [15:0] cmd_ff, nxt_cmd, ramp_ff, nxt_ramp, stat_ff, nxt_stat;
  logic [15:0] act1_ff, nxt_act1, act2_ff, nxt_act2;
  logic [15:0] dcmd_ff, nxt_dcmd, dstat_ff, nxt_dstat, dr1_ff, nxt_dr1, dr2_ff, nxt_dr2;
  logic [15:0] da1_ff, nxt_da1, da2_ff, nxt_da2;
  logic        rst_bit_ff, nxt_rst_bit, coast_ff, nxt_coast, quick_ff, nxt_quick;
  logic [15:0] cw, rin;
  logic        run_en, rst_edge, dbg_on;

  always_comb begin
    // latch the command word only on a cycle strobe
    nxt_cmd     = link.cycle_stb ? link.cmd_word : cmd_ff;
    cw          = net_ctrl_sel_i ? cmd_ff : local_cmd_i;
    run_en      = net_run_en_sel_i ? cw[CW_RUN] : local_run_en_i;
    nxt_rst_bit = cw[CW_RESET];
    rst_edge    = cw[CW_RESET] & ~rst_bit_ff & net_reset_sel_i;
    nxt_st      = st_ff;
    nxt_coast   = 1'b0;
    nxt_quick   = 1'b0;
    if (fault_i) begin
      nxt_st = ST_FAULT;
    end else begin
      unique case (st_ff)
        ST_NOT_READY: nxt_st = ST_INHIBITED;
        ST_FAULT: if (rst_edge) nxt_st = ST_INHIBITED;
        ST_COAST_STOP: if (stop_done_i) nxt_st = ST_INHIBITED;
        ST_QUICK_STOP: if (stop_done_i) nxt_st = ST_INHIBITED;
        ST_RAMP_STOP: begin
          if (!cw[CW_COAST_STOP]) nxt_st = ST_COAST_STOP;
          else if (!cw[CW_QUICK_STOP]) nxt_st = ST_QUICK_STOP;
          else if (stop_done_i) nxt_st = ST_READY_ON;
        end
        default: begin
          // interlocks take priority, coast stop first
          if (!cw[CW_COAST_STOP])
            nxt_st = (st_ff == ST_INHIBITED) ? ST_INHIBITED : ST_COAST_STOP;
          else if (!cw[CW_QUICK_STOP])
            nxt_st = (st_ff == ST_INHIBITED) ? ST_INHIBITED : ST_QUICK_STOP;
          else if (!cw[CW_RAMP_STOP])
            nxt_st = (st_ff == ST_OP_ENABLED || st_ff == ST_READY_RUN) ? ST_RAMP_STOP : ST_READY_ON;
          else if (st_ff == ST_READY_ON || st_ff == ST_INHIBITED)
            nxt_st = (st_ff == ST_INHIBITED) ? ST_READY_ON : ST_READY_RUN;
          else if (cw[CW_RUN] && run_en)
            nxt_st = ST_OP_ENABLED;
          else
            nxt_st = ST_READY_RUN;
        end
      endcase
    end
    nxt_coast = (nxt_st == ST_COAST_STOP);
    nxt_quick = (nxt_st == ST_QUICK_STOP);
    // ramp input forced to zero only when the network owns bit 6
    rin = net_ref_sel_i ? ref1_scaled : local_ref_i;
    if (net_ramp_in_sel_i && !cw[CW_RAMP_IN]) rin = 16'h0000;
    nxt_ramp = ramp_ff;
    if (st_ff != ST_OP_ENABLED || !cw[CW_RAMP_OUT])
      nxt_ramp = 16'h0000;
    else if (cw[CW_RAMP_HOLD])
      nxt_ramp = rin;
    // status word back to the master
    nxt_stat = 16'h0000;
    nxt_stat[SW_RDY_ON]    = (st_ff == ST_READY_ON) || (st_ff == ST_READY_RUN) || (st_ff == ST_OP_ENABLED);
    nxt_stat[SW_RDY_RUN]   = (st_ff == ST_READY_RUN) || (st_ff == ST_OP_ENABLED);
    nxt_stat[SW_RDY_REF]   = (st_ff == ST_OP_ENABLED);
    nxt_stat[SW_TRIPPED]   = (st_ff == ST_FAULT);
    nxt_stat[SW_COAST_OFF] = (st_ff != ST_COAST_STOP);
    nxt_stat[SW_QUICK_OFF] = (st_ff != ST_QUICK_STOP);
    nxt_stat[SW_INHIBIT]   = (st_ff == ST_INHIBITED);
    nxt_stat[SW_AT_SET]    = (st_ff == ST_OP_ENABLED) && (ramp_ff == rin);
    nxt_stat[SW_REMOTE]    = net_ctrl_sel_i;
    nxt_act1 = act_pick(act1_type_i, speed_act_i, torque_act_i, ramp_ff);
    nxt_act2 = act_pick(act2_type_i, speed_act_i, torque_act_i, ramp_ff);
    // mirrors hold zero while debug is off
    dbg_on    = (dbg_mode_i == DBG_FAST) || (dbg_mode_i == DBG_NORMAL);
    nxt_dcmd  = dbg_on ? cmd_ff : 16'h0000;
    nxt_dstat = dbg_on ? stat_ff : 16'h0000;
    nxt_dr1   = dbg_on ? link.ref1_word : 16'h0000;
    nxt_dr2   = dbg_on ? link.ref2_word : 16'h0000;
    nxt_da1   = dbg_on ? act1_ff : 16'h0000;
    nxt_da2   = dbg_on ? act2_ff : 16'h0000;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= ST_NOT_READY;
      ramp_ff <= 16'h0000;
      cmd_ff <= RESET_WORD;
      stat_ff <= 16'h0000;
      act1_ff <= 16'h0000;
      act2_ff <= 16'h0000;
      dcmd_ff <= 16'h0000;
      dstat_ff <= 16'h0000;
      dr1_ff <= 16'h0000;
      dr2_ff <= 16'h0000;
      da1_ff <= 16'h0000;
      da2_ff <= 16'h0000;
      rst_bit_ff <= 1'b0;
      coast_ff <= 1'b0;
      quick_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ramp_ff <= nxt_ramp;
      cmd_ff <= nxt_cmd;
      stat_ff <= nxt_stat;
      act1_ff <= nxt_act1;
      act2_ff <= nxt_act2;
      dcmd_ff <= nxt_dcmd;
      dstat_ff <= nxt_dstat;
      dr1_ff <= nxt_dr1;
      dr2_ff <= nxt_dr2;
      da1_ff <= nxt_da1;
      da2_ff <= nxt_da2;
      rst_bit_ff <= nxt_rst_bit;
      coast_ff <= nxt_coast;
      quick_ff <= nxt_quick;
    end
  end
  // ==========================================================================
  // outputs
  assign state_o        = st_ff;
  assign ramp_out_o     = ramp_ff;
  assign coast_o        = coast_ff;
  assign quick_o        = quick_ff;
  assign dbg_cmd_o      = dcmd_ff;
  assign dbg_stat_o     = dstat_ff;
  assign dbg_ref1_o     = dr1_ff;
  assign dbg_ref2_o     = dr2_ff;
  assign dbg_act1_o     = da1_ff;
  assign dbg_act2_o     = da2_ff;
  assign link.stat_word = stat_ff;
  assign link.act1_word = act1_ff;
  assign link.act2_word = act2_ff;
endmodule // fcw_drive

// ==== logic/fcw_pkg.sv ====
// shared constants and types for the network control word interpreter
package fcw_pkg;
  // ==========================================================================
  // word geometry
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned WIDE_W        = 32;
  localparam int unsigned MAX_WORDS     = 12;
  localparam int unsigned MAG_W         = 15;
  localparam int unsigned SIGN_POS      = 15;
  // ==========================================================================
  // command word bit positions
  localparam int unsigned CW_RAMP_STOP  = 0;
  localparam int unsigned CW_COAST_STOP = 1;
  localparam int unsigned CW_QUICK_STOP = 2;
  localparam int unsigned CW_RUN        = 3;
  localparam int unsigned CW_RAMP_OUT   = 4;
  localparam int unsigned CW_RAMP_HOLD  = 5;
  localparam int unsigned CW_RAMP_IN    = 6;
  localparam int unsigned CW_RESET      = 7;
  // ==========================================================================
  // status word bit positions
  localparam int unsigned SW_RDY_ON     = 0;
  localparam int unsigned SW_RDY_RUN    = 1;
  localparam int unsigned SW_RDY_REF    = 2;
  localparam int unsigned SW_TRIPPED    = 3;
  localparam int unsigned SW_COAST_OFF  = 4;
  localparam int unsigned SW_QUICK_OFF  = 5;
  localparam int unsigned SW_INHIBIT    = 6;
  localparam int unsigned SW_AT_SET     = 8;
  localparam int unsigned SW_REMOTE     = 9;
  // ==========================================================================
  // APB register offsets (byte addresses)
  localparam logic [7:0] A_CMD_OFS      = 8'h00;
  localparam logic [7:0] A_REF1_OFS     = 8'h04;
  localparam logic [7:0] A_REF2_OFS     = 8'h08;
  localparam logic [7:0] A_STAT_OFS     = 8'h0C;
  localparam logic [7:0] A_ACT1_OFS     = 8'h10;
  localparam logic [7:0] A_ACT2_OFS     = 8'h14;
  localparam logic [7:0] A_CNT_OFS      = 8'h18;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  // ==========================================================================
  // debug and type settings
  typedef enum logic [1:0] {DBG_OFF, DBG_FAST, DBG_NORMAL} fcw_dbg_e;
  typedef enum logic [1:0] {REF_SPEED, REF_TORQUE, REF_FREQ, REF_RAW} fcw_ref_type_e;
  typedef enum logic [1:0] {ACT_SPEED, ACT_TORQUE, ACT_FREQ, ACT_RAMP} fcw_act_type_e;
  typedef enum logic [3:0] {
    ST_NOT_READY, ST_INHIBITED, ST_READY_ON, ST_READY_RUN, ST_OP_ENABLED,
    ST_RAMP_STOP, ST_COAST_STOP, ST_QUICK_STOP, ST_FAULT
  } fcw_state_e;

  // two's complement negation of a sign-magnitude style reference
  function automatic logic [15:0] fcw_neg(input logic [15:0] v);
    fcw_neg = 16'(~v + 16'h0001);
  endfunction
endpackage

// ==== logic/fcw_link_if.sv ====
// cyclic word link between network master and drive
`timescale 1ns/1ns
interface fcw_link_if;
  logic        cycle_stb;
  logic [15:0] cmd_word;
  logic [15:0] ref1_word;
  logic [15:0] ref2_word;
  logic [15:0] stat_word;
  logic [15:0] act1_word;
  logic [15:0] act2_word;
  modport master (output cycle_stb, output cmd_word, output ref1_word, output ref2_word,
                  input stat_word, input act1_word, input act2_word);
  modport drive  (input cycle_stb, input cmd_word, input ref1_word, input ref2_word,
                  output stat_word, output act1_word, output act2_word);
endinterface

// ==== logic/fcw_ref_scale.sv ====
// per-reference scaling selected by a type setting
`timescale 1ns/1ns
module fcw_ref_scale
  import fcw_pkg::*;
(
  input  wire logic [15:0]  raw_i,
  input  wire logic [1:0]   type_i,
  output logic      [15:0]  scaled_o
);
  logic [15:0] mag;
  logic [15:0] shifted;
  always_comb begin
    // sign and 15-bit magnitude; negative is two's complement
    mag     = raw_i[SIGN_POS] ? fcw_neg(raw_i) : raw_i;
    shifted = 16'h0000;
    unique case (type_i)
      REF_SPEED:  shifted = mag;
      REF_TORQUE: shifted = {1'b0, mag[15:1]};
      REF_FREQ:   shifted = {2'b00, mag[15:2]};
      default:    shifted = mag;
    endcase
    scaled_o = (type_i == REF_RAW) ? raw_i : (raw_i[SIGN_POS] ? fcw_neg(shifted) : shifted);
  end
endmodule // fcw_ref_scale

// ==== logic/fcw_master.sv ====
// network master end: APB registers to cyclic link
`timescale 1ns/1ns
module fcw_master
  import fcw_pkg::*;
#(
  parameter int unsigned CYCLE_DIV = 16
)(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  fcw_link_if.master       link
);
  import fcw_pkg::*;
  if (CYCLE_DIV < 2 || CYCLE_DIV > 65535) begin : g_bad_div
    $error("bad CYCLE_DIV");
  end
  // ==========================================================================
  // registers
  logic [15:0] cmd_ff, nxt_cmd, ref1_ff, nxt_ref1, ref2_ff, nxt_ref2;
  logic [15:0] div_ff, nxt_div, cnt_ff, nxt_cnt;
  logic        stb_ff, nxt_stb;
  logic [31:0] rd_ff, nxt_rd;
  logic        rdy_ff, nxt_rdy, err_ff, nxt_err;
  logic        acc, wr_go;
  always_comb begin
    acc      = psel_i & penable_i & ~rdy_ff;
    // write lands only at the edge that also sees pready high
    wr_go    = psel_i & penable_i & pwrite_i & rdy_ff;
    nxt_cmd  = cmd_ff;
    nxt_ref1 = ref1_ff;
    nxt_ref2 = ref2_ff;
    nxt_rd   = rd_ff;
    nxt_rdy  = acc;
    nxt_err  = 1'b0;
    nxt_div  = (div_ff == 16'(CYCLE_DIV - 1)) ? 16'h0000 : 16'(div_ff + 16'h0001);
    nxt_stb  = (div_ff == 16'h0000);
    nxt_cnt  = nxt_stb ? 16'(cnt_ff + 16'h0001) : cnt_ff;
    if (wr_go) begin
      unique case (paddr_i)
        A_CMD_OFS:  nxt_cmd  = pwdata_i[15:0];
        A_REF1_OFS: nxt_ref1 = pwdata_i[15:0];
        A_REF2_OFS: nxt_ref2 = pwdata_i[15:0];
        default:    nxt_cmd  = cmd_ff;
      endcase
    end
    if (acc && pwrite_i) begin
      nxt_err = !(paddr_i inside {A_CMD_OFS, A_REF1_OFS, A_REF2_OFS});
    end else if (acc) begin
      unique case (paddr_i)
        A_CMD_OFS:  nxt_rd = {16'h0000, cmd_ff};
        A_REF1_OFS: nxt_rd = {16'h0000, ref1_ff};
        A_REF2_OFS: nxt_rd = {16'h0000, ref2_ff};
        A_STAT_OFS: nxt_rd = {16'h0000, link.stat_word};
        A_ACT1_OFS: nxt_rd = {16'h0000, link.act1_word};
        A_ACT2_OFS: nxt_rd = {16'h0000, link.act2_word};
        A_CNT_OFS:  nxt_rd = {16'h0000, cnt_ff};
        default: begin
          nxt_rd  = 32'h0000_0000;
          nxt_err = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_ff <= RESET_WORD;
      ref1_ff <= RESET_WORD;
      ref2_ff <= RESET_WORD;
      div_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      stb_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      cmd_ff <= nxt_cmd;
      ref1_ff <= nxt_ref1;
      ref2_ff <= nxt_ref2;
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      stb_ff <= nxt_stb;
      rd_ff <= nxt_rd;
      rdy_ff <= nxt_rdy;
      err_ff <= nxt_err;
    end
  end
  assign prdata_o       = rd_ff;
  assign pready_o       = rdy_ff;
  assign pslverr_o      = err_ff;
  // three 16-bit words out per cycle, within the twelve-word ceiling
  assign link.cycle_stb = stb_ff;
  assign link.cmd_word  = cmd_ff;
  assign link.ref1_word = ref1_ff;
  assign link.ref2_word = ref2_ff;
endmodule // fcw_master

// ==== testbench/fcw_link_properties.sv ====
// link timing and drive state properties for the control word interpreter
`timescale 1ns/1ns
module fcw_link_properties
  import fcw_pkg::*;
#(
  parameter int unsigned CYCLE_DIV = 16
)(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        cycle_stb,
  input  wire logic [15:0] cmd_word,
  input  wire logic [15:0] stat_word,
  input  wire fcw_state_e  state_o,
  input  wire logic [15:0] ramp_out_o,
  input  wire logic        fault_i,
  input  wire logic        net_ctrl_sel_i
);
  // ==========================================================================
  // strobe gap counter, first strobe after reset has no reference point
  logic [15:0] gap_ff, nxt_gap;
  logic        seen_ff, nxt_seen;
  always_comb begin
    nxt_gap  = cycle_stb ? 16'h0001 : gap_ff + 16'h0001;
    nxt_seen = seen_ff | cycle_stb;
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_ff  <= 16'h0000;
      seen_ff <= 1'b0;
    end else begin
      gap_ff  <= nxt_gap;
      seen_ff <= nxt_seen;
    end
  end
  // ==========================================================================
  // assertions
  default clocking dflt_cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  stb_spacing_a: assert property (cycle_stb && seen_ff |-> gap_ff == 16'(CYCLE_DIV))
    else $error("strobe spacing wrong");
  stb_missing_a: assert property (seen_ff |-> gap_ff <= 16'(CYCLE_DIV))
    else $error("strobe missing");
  // sampled reset term keeps the release edge itself out of the antecedent
  reset_entry_a: assert property (resetn_i && state_o == ST_NOT_READY && !fault_i
                                  |=> state_o != ST_NOT_READY)
    else $error("stuck in not ready");
  fault_entry_a: assert property (fault_i |-> ##[1:2] state_o == ST_FAULT)
    else $error("fault not entered");
  tripped_stat_a: assert property (state_o == ST_FAULT |=> stat_word[SW_TRIPPED])
    else $error("tripped bit missing");
  inhibit_stat_a: assert property (state_o == ST_INHIBITED |=> stat_word[SW_INHIBIT])
    else $error("inhibit bit missing");
  op_stat_a: assert property (state_o == ST_OP_ENABLED |=> stat_word[SW_RDY_REF])
    else $error("ready ref bit missing");
  coast_stat_a: assert property (state_o == ST_COAST_STOP |=> !stat_word[SW_COAST_OFF])
    else $error("coast off bit set in coast stop");
  ramp_zero_a: assert property (state_o != ST_OP_ENABLED && $past(state_o) != ST_OP_ENABLED
                                |-> ramp_out_o == 16'h0000)
    else $error("ramp output nonzero outside operation");
  coast_cmd_a: assert property (cycle_stb && net_ctrl_sel_i && !fault_i && state_o != ST_FAULT
                                && !cmd_word[CW_COAST_STOP]
                                |-> ##[2:3] (state_o inside {ST_COAST_STOP, ST_INHIBITED}))
    else $error("coast command ignored");
  // ==========================================================================
  // coverage of main scenarios
  op_seen_c: cover property (state_o == ST_OP_ENABLED);
  ramp_stop_c: cover property (state_o == ST_RAMP_STOP);
  fault_seen_c: cover property (state_o == ST_FAULT);
endmodule // fcw_link_properties

// ==== testbench/tb_top.sv ====
// self-checking bench: master and drive ends joined over the cyclic link
`timescale 1ns/1ns
module tb_top;
  import fcw_pkg::*;
  localparam int unsigned CDIV = 4; // short cycle keeps the run brief
  // ==========================================================================
  // stimulus and observed signals
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  fcw_dbg_e    dbg_mode;
  logic [1:0]  r1t, r2t, a1t, a2t;
  logic        s_ctrl, s_ref, s_run, s_rin, s_rst, l_run, fault, sdone, coast, quick;
  logic [15:0] l_cmd, l_ref, speed, torque, ramp, v, w;
  logic [15:0] d_cmd, d_stat, d_ref1, d_ref2, d_act1, d_act2;
  fcw_state_e  state;
  int          n_errors, total_checks, seed;
  fcw_link_if  link ();
  always #4 clk = ~clk;
  // ==========================================================================
  // both ends and the checker
  fcw_master #(.CYCLE_DIV(CDIV)) fcw_master_i (.ref_clk_i(clk), .resetn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link(link));
  fcw_drive fcw_drive_i (.ref_clk_i(clk), .resetn_i(rstn), .link(link), .dbg_mode_i(dbg_mode),
    .ref1_type_i(r1t), .ref2_type_i(r2t), .act1_type_i(a1t), .act2_type_i(a2t), .net_ctrl_sel_i(s_ctrl),
    .net_ref_sel_i(s_ref), .net_run_en_sel_i(s_run), .net_ramp_in_sel_i(s_rin), .net_reset_sel_i(s_rst),
    .local_cmd_i(l_cmd), .local_ref_i(l_ref), .local_run_en_i(l_run), .fault_i(fault), .stop_done_i(sdone),
    .speed_act_i(speed), .torque_act_i(torque), .state_o(state), .ramp_out_o(ramp), .coast_o(coast),
    .quick_o(quick), .dbg_cmd_o(d_cmd), .dbg_stat_o(d_stat), .dbg_ref1_o(d_ref1), .dbg_ref2_o(d_ref2),
    .dbg_act1_o(d_act1), .dbg_act2_o(d_act2));
  fcw_link_properties #(.CYCLE_DIV(CDIV)) fcw_link_properties_i (.ref_clk_i(clk), .resetn_i(rstn),
    .cycle_stb(link.cycle_stb), .cmd_word(link.cmd_word), .stat_word(link.stat_word), .state_o(state),
    .ramp_out_o(ramp), .fault_i(fault), .net_ctrl_sel_i(s_ctrl));
  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // entered just after a rising edge; reads see the values sampled at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle();
    repeat (CDIV + 4) @(posedge clk);
  endtask
  task automatic wcmd(input logic [15:0] c);
    apb(1'b1, A_CMD_OFS, {16'h0000, c});
    settle();
  endtask
  // network or local command, then bounded wait for the expected state
  task automatic go(input logic net, input logic [15:0] c, input logic sd, input fcw_state_e st);
    int n;
    sdone <= sd;
    if (net) apb(1'b1, A_CMD_OFS, {16'h0000, c});
    else l_cmd <= c;
    n = 0;
    while (state !== st && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("state", 32'(st), 32'(state));
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    clk = 0;
    rstn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    dbg_mode = DBG_FAST;
    r1t = 2'h3;
    r2t = 2'h0;
    a1t = 2'h1;
    a2t = 2'h2;
    {s_ctrl, s_ref, s_run, s_rin, s_rst} = 5'h1F;
    l_run = 0;
    fault = 0;
    sdone = 0;
    l_cmd = 0;
    l_ref = 0;
    seed = 39415;
    speed = 16'h1234;
    torque = 16'h0ABC;
    n_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("state", 32'(ST_INHIBITED), 32'(state));
    chk("ramp", 32'h0, {16'h0, ramp});
    v = (16'($random(seed)) & 16'h7FFF) | 16'h0001;
    w = 16'h0000 - v; // reversed direction
    apb(1'b1, A_REF1_OFS, {16'hFFFF, v});
    apb(1'b1, A_REF2_OFS, {16'h0000, w});
    apb(1'b0, A_REF1_OFS, 32'h0);
    chk("ref1 read", {16'h0000, v}, q);
    settle();
    chk("ref1 mirror", {16'h0, v}, {16'h0, d_ref1});
    chk("ref2 sign", 32'h1, {31'h0, d_ref2[SIGN_POS]});
    chk("ref2 mirror", {16'h0, w}, {16'h0, d_ref2});
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, A_STAT_OFS, 32'h0000_FFFF);
    chk("status write err", 32'h1, {31'h0, e});
    go(1'b1, 16'h0006, 1'b0, ST_READY_ON);
    go(1'b1, 16'h0007, 1'b0, ST_READY_RUN);
    go(1'b1, 16'h007F, 1'b0, ST_OP_ENABLED);
    apb(1'b0, A_STAT_OFS, 32'h0);
    chk("ready ref", 32'h1, {31'h0, q[SW_RDY_REF]});
    go(1'b1, 16'h0077, 1'b0, ST_READY_RUN);
    go(1'b1, 16'h007F, 1'b0, ST_OP_ENABLED);
    go(1'b1, 16'h007E, 1'b0, ST_RAMP_STOP);
    go(1'b1, 16'h007E, 1'b1, ST_READY_ON);
    go(1'b1, 16'h007F, 1'b0, ST_OP_ENABLED);
    go(1'b1, 16'h007D, 1'b0, ST_COAST_STOP);
    chk("coast", 32'h1, {31'h0, coast});
    go(1'b1, 16'h007D, 1'b1, ST_INHIBITED);
    go(1'b1, 16'h0006, 1'b0, ST_READY_ON);
    go(1'b1, 16'h0007, 1'b0, ST_READY_RUN);
    go(1'b1, 16'h007B, 1'b0, ST_QUICK_STOP);
    chk("quick", 32'h1, {31'h0, quick});
    go(1'b1, 16'h007B, 1'b1, ST_INHIBITED);
    s_rst <= 1'b0;
    fault <= 1'b1;
    go(1'b1, 16'h0006, 1'b0, ST_FAULT);
    apb(1'b0, A_STAT_OFS, 32'h0);
    chk("tripped", 32'h1, {31'h0, q[SW_TRIPPED]});
    fault <= 1'b0;
    wcmd(16'h0086);
    chk("state", 32'(ST_FAULT), 32'(state));
    s_rst <= 1'b1;
    wcmd(16'h0006);
    go(1'b1, 16'h0086, 1'b0, ST_INHIBITED);
    // network asks for coast; local source must win once deselected
    wcmd(16'h007D);
    // switch source two edges after a strobe, so no latched word is in flight
    for (int k = 0; k < 8 && !link.cycle_stb; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    s_ctrl <= 1'b0;
    s_run <= 1'b0;
    s_ref <= 1'b0;
    l_ref <= 16'($random(seed)) & 16'h3FFF;
    go(1'b0, 16'h0006, 1'b1, ST_READY_ON);
    go(1'b0, 16'h007F, 1'b0, ST_READY_RUN);
    l_run <= 1'b1;
    go(1'b0, 16'h007F, 1'b0, ST_OP_ENABLED);
    settle();
    chk("ramp follow", {16'h0, l_ref}, {16'h0, ramp});
    l_cmd <= 16'h005F;
    settle();
    v = ramp;
    // move the input while held; nonzero keeps the at-setpoint bit low later
    l_ref <= (v ^ 16'h0155) | 16'h0001;
    repeat (8) @(posedge clk);
    chk("ramp hold", {16'h0, v}, {16'h0, ramp});
    l_cmd <= 16'h006F;
    settle();
    chk("ramp zero", 32'h0, {16'h0, ramp});
    for (int m = 0; m < 3; m++) begin
      dbg_mode <= fcw_dbg_e'(m);
      speed <= 16'($random(seed)) & 16'h7FFE;
      torque <= 16'($random(seed));
      settle();
      apb(1'b0, A_ACT1_OFS, 32'h0);
      chk("act1", {16'h0, torque}, q);
      chk("dbg act1", (m == 0) ? 32'h0 : {16'h0, torque}, {16'h0, d_act1});
      apb(1'b0, A_ACT2_OFS, 32'h0);
      chk("act2", {17'h0, speed[15:1]}, q);
      chk("dbg act2", (m == 0) ? 32'h0 : {17'h0, speed[15:1]}, {16'h0, d_act2});
      chk("dbg cmd", (m == 0) ? 32'h0 : 32'h0000_007D, {16'h0, d_cmd});
      apb(1'b0, A_STAT_OFS, 32'h0);
      // operation enabled, ramp forced to zero, local control: bits 0,1,2,4,5
      chk("status", 32'h0000_0037, q);
      chk("dbg stat", (m == 0) ? 32'h0 : 32'h0000_0037, {16'h0, d_stat});
    end
    wrap_up();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule // tb_top
